// *** common/bala_pkg.sv ***
// package for the byte alu slice: operation codes, widths, reset values
// assumes a single clock domain shared with the processor core
package bala_pkg;
  // ==========================================================
  // widths and sizes
  localparam int DATA_W = 8;
  localparam int REG_COUNT = 16;
  localparam int REG_SEL_W = 4;
  localparam int BANK_COUNT = 2;
  // ==========================================================
  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic CARRY_RESET = 1'b0;
  // ==========================================================
  // operations
  typedef enum logic [2:0] {
    BALA_OP_OR,
    BALA_OP_XOR,
    BALA_OP_ADD,
    BALA_OP_ADD_CARRY,
    BALA_OP_SUB,
    BALA_OP_SUB_BORROW
  } bala_op_t;
endpackage

// *** design/bala_calc.sv ***
// combinational arithmetic/logic core of the byte alu slice
// assumes operands are already selected by the caller
`timescale 1ns/1ps
module bala_calc (
  input wire bala_pkg::bala_op_t op,
  input wire logic [7:0] dest_val,
  input wire logic [7:0] src_val,
  input wire logic carry_in,
  input wire logic zero_in,
  output logic [7:0] result,
  output logic carry_out,
  output logic zero_out
);
  import bala_pkg::*;

  // ==========================================================
  // nine-bit sums keep the carry/borrow in bit 8
  wire logic use_cy = (op == BALA_OP_ADD_CARRY) || (op == BALA_OP_SUB_BORROW);
  wire logic cy_term = use_cy & carry_in;
  wire logic [8:0] sum9 = {1'b0, dest_val} + {1'b0, src_val} + {8'h00, cy_term};
  // unsigned borrow sets bit 8 when the true difference is negative
  wire logic [8:0] diff9 = {1'b0, dest_val} - {1'b0, src_val} - {8'h00, cy_term};
  wire logic res_zero = (result == 8'h00);

  always_comb begin
    result = dest_val;
    carry_out = 1'b0;
    unique case (op)
      BALA_OP_OR: begin
        result = dest_val | src_val;
        carry_out = 1'b0;
      end
      BALA_OP_XOR: begin
        result = dest_val ^ src_val;
        carry_out = 1'b0;
      end
      BALA_OP_ADD, BALA_OP_ADD_CARRY: begin
        result = sum9[7:0];
        carry_out = sum9[8];
      end
      BALA_OP_SUB, BALA_OP_SUB_BORROW: begin
        result = diff9[7:0];
        carry_out = diff9[8];
      end
      default: begin
        result = dest_val;
        carry_out = 1'b0;
      end
    endcase
  end

  // chained forms only keep zero if every earlier byte was zero too
  assign zero_out = use_cy ? (res_zero & zero_in) : res_zero;
endmodule

// *** design/bala_slice.sv ***
// byte alu execution slice: register banks, flags, result write-back
// assumes decode delivers one operation per cycle with exec_valid
// Operation
// - or: result back, zero from result, carry cleared
// - xor with immediate or register, write back
// - xor: zero if result zero, carry forced clear
// - add: low eight bits of sum stored
// - add: carry on overflow, zero on result
// - add with carry uses prior flags
// - add with carry: zero needs prior zero
// - sub: stores eight-bit difference
// - sub: zero on result, carry as borrow
// - unsigned operands, two's complement wrap
// - sub with borrow subtracts prior carry
// - sub with borrow: zero needs prior zero
// - register operands pick one of sixteen
`timescale 1ns/1ps
module bala_slice (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic exec_valid,
  input wire bala_pkg::bala_op_t exec_op,
  input wire logic use_immediate,
  input wire logic [3:0] dest_sel,
  input wire logic [3:0] src_sel,
  input wire logic [7:0] immediate_byte,
  input wire logic bank_sel,
  input wire logic [3:0] peek_sel,
  output logic [7:0] peek_data,
  output logic [7:0] result_data,
  output logic zero_flag,
  output logic carry_flag
);
  import bala_pkg::*;

  // ==========================================================
  // register banks
  logic [7:0] bank_reg [BANK_COUNT*REG_COUNT];
  logic zero_reg;
  logic carry_reg;
  logic [7:0] result_reg;
  logic [7:0] peek_reg;

  // sixteen registers per bank; bank bit forms the high address bit
  function automatic logic [4:0] reg_addr(input logic bank, input logic [3:0] sel);
    reg_addr = {bank, sel};
  endfunction

  wire logic [7:0] dest_operand_register = bank_reg[reg_addr(bank_sel, dest_sel)];
  wire logic [7:0] source_operand_register = bank_reg[reg_addr(bank_sel, src_sel)];
  wire logic [7:0] src_val = use_immediate ? immediate_byte : source_operand_register;

  logic [7:0] calc_result;
  logic calc_carry;
  logic calc_zero;

  bala_calc u_calc (
    .op(exec_op),
    .dest_val(dest_operand_register),
    .src_val(src_val),
    .carry_in(carry_reg),
    .zero_in(zero_reg),
    .result(calc_result),
    .carry_out(calc_carry),
    .zero_out(calc_zero)
  );

  // ==========================================================
  // write-back and flags
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < BANK_COUNT*REG_COUNT; i++) begin
        bank_reg[i] <= REG_RESET;
      end
    end else if (exec_valid) begin
      bank_reg[reg_addr(bank_sel, dest_sel)] <= calc_result;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      zero_reg <= ZERO_RESET;
      carry_reg <= CARRY_RESET;
      result_reg <= REG_RESET;
    end else if (exec_valid) begin
      zero_reg <= calc_zero;
      carry_reg <= calc_carry;
      result_reg <= calc_result;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      peek_reg <= REG_RESET;
    end else begin
      peek_reg <= bank_reg[reg_addr(bank_sel, peek_sel)];
    end
  end

  assign peek_data = peek_reg;
  assign result_data = result_reg;
  assign zero_flag = zero_reg;
  assign carry_flag = carry_reg;

  // ==========================================================
  // checks
  wire logic [8:0] ref_sum = {1'b0, dest_operand_register} + {1'b0, src_val}
                             + {8'h00, carry_reg};
  wire logic [8:0] ref_dif = {1'b0, dest_operand_register} - {1'b0, src_val}
                             - {8'h00, carry_reg};

  sequence s_exec(bala_op_t o);
    exec_valid && exec_op == o;
  endsequence

  sequence s_exec_any;
    exec_valid;
  endsequence

  property p_or_flags;
    @(posedge clk_sys) disable iff (!nrst)
      s_exec(BALA_OP_OR) |=> !carry_flag && zero_flag == (result_data == 8'h00);
  endproperty
  a_or_flags: assert property (p_or_flags) else $error("or flags wrong");

  property p_or_result;
    logic [7:0] exp;
    @(posedge clk_sys) disable iff (!nrst)
      (s_exec(BALA_OP_OR), exp = dest_operand_register | src_val) |=> result_data == exp;
  endproperty
  a_or_result: assert property (p_or_result) else $error("or result wrong");

  property p_xor_result;
    logic [7:0] exp;
    @(posedge clk_sys) disable iff (!nrst)
      (s_exec(BALA_OP_XOR), exp = dest_operand_register ^ src_val) |=> result_data == exp;
  endproperty
  a_xor_result: assert property (p_xor_result) else $error("xor result wrong");

  property p_xor_flags;
    @(posedge clk_sys) disable iff (!nrst)
      s_exec(BALA_OP_XOR) |=> !carry_flag && zero_flag == (result_data == 8'h00);
  endproperty
  a_xor_flags: assert property (p_xor_flags) else $error("xor flags wrong");

  property p_add;
    logic [8:0] exp;
    @(posedge clk_sys) disable iff (!nrst)
      (s_exec(BALA_OP_ADD), exp = {1'b0, dest_operand_register} + {1'b0, src_val})
      |=> result_data == exp[7:0] && carry_flag == exp[8];
  endproperty
  a_add: assert property (p_add) else $error("add wrong");

  property p_add_zero;
    @(posedge clk_sys) disable iff (!nrst)
      s_exec(BALA_OP_ADD) |=> zero_flag == (result_data == 8'h00);
  endproperty
  a_add_zero: assert property (p_add_zero) else $error("add zero wrong");

  property p_add_carry;
    logic [8:0] exp;
    logic zp;
    @(posedge clk_sys) disable iff (!nrst)
      (s_exec(BALA_OP_ADD_CARRY), exp = ref_sum, zp = zero_reg)
      |=> result_data == exp[7:0] && carry_flag == exp[8]
          && zero_flag == (zp && exp[7:0] == 8'h00);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add with carry wrong");

  property p_add_carry_zero;
    @(posedge clk_sys) disable iff (!nrst)
      s_exec(BALA_OP_ADD_CARRY) ##0 !zero_flag |=> !zero_flag;
  endproperty
  a_add_carry_zero: assert property (p_add_carry_zero) else $error("chain zero wrong");

  // a zero upper byte must not lose the zero already built by the lower bytes
  property p_carry_zero_keep;
    @(posedge clk_sys) disable iff (!nrst)
      s_exec(BALA_OP_ADD_CARRY) ##0 (zero_flag && ref_sum[7:0] == 8'h00) |=> zero_flag;
  endproperty
  a_carry_zero_keep: assert property (p_carry_zero_keep) else $error("zero lost");

  property p_sub;
    logic [8:0] exp;
    @(posedge clk_sys) disable iff (!nrst)
      (s_exec(BALA_OP_SUB), exp = {1'b0, dest_operand_register} - {1'b0, src_val})
      |=> result_data == exp[7:0] && carry_flag == exp[8]
          && zero_flag == (exp[7:0] == 8'h00);
  endproperty
  a_sub: assert property (p_sub) else $error("sub wrong");

  property p_sub_borrow;
    logic [8:0] exp;
    logic zp;
    @(posedge clk_sys) disable iff (!nrst)
      (s_exec(BALA_OP_SUB_BORROW), exp = ref_dif, zp = zero_reg)
      |=> result_data == exp[7:0] && carry_flag == exp[8]
          && zero_flag == (zp && exp[7:0] == 8'h00);
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("sub with borrow wrong");

  property p_idle_hold;
    @(posedge clk_sys) disable iff (!nrst)
      !exec_valid |=> $stable(zero_flag) && $stable(carry_flag) && $stable(result_data);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("state moved while idle");

  // the register picked by dest_sel in the active bank must hold what result_data shows
  property p_write_back;
    logic [4:0] addr;
    @(posedge clk_sys) disable iff (!nrst)
      (s_exec_any, addr = reg_addr(bank_sel, dest_sel)) |=> bank_reg[addr] == result_data;
  endproperty
  a_write_back: assert property (p_write_back) else $error("write-back went astray");

  // decode may leave a stale op on the bus; without exec_valid the register picked by dest_sel may not move
  property p_idle_regs;
    logic [4:0] addr;
    logic [7:0] held;
    @(posedge clk_sys) disable iff (!nrst)
      (!exec_valid, addr = reg_addr(bank_sel, dest_sel), held = dest_operand_register)
      |=> bank_reg[addr] == held;
  endproperty
  a_idle_regs: assert property (p_idle_regs) else $error("register moved while idle");
endmodule

// *** tb/bala_slice_bench.sv ***
// self-checking bench for the byte alu slice: one task per scenario
// assumes registers and flags clear at reset and results show one cycle later
`timescale 1ns/1ps
module bala_slice_bench;
  import bala_pkg::*;
  // ==========================================================
  // stimulus and observation
  localparam logic I = 1'h1;
  localparam logic R = 1'h0;
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic exec_valid = 1'h0;
  bala_op_t exec_op = BALA_OP_OR;
  logic use_immediate = 1'h0;
  logic [3:0] dest_sel = 4'h0;
  logic [3:0] src_sel = 4'h0;
  logic [7:0] immediate_byte = 8'h00;
  logic bank_sel = 1'h0;
  logic [3:0] peek_sel = 4'h0;
  logic [7:0] peek_data;
  logic [7:0] result_data;
  logic zero_flag;
  logic carry_flag;
  int n_errors = 0;
  int checks = 0;
  always #20 clk_sys = ~clk_sys;
  bala_slice dut (.clk_sys(clk_sys), .nrst(nrst), .exec_valid(exec_valid), .exec_op(exec_op),
    .use_immediate(use_immediate), .dest_sel(dest_sel), .src_sel(src_sel),
    .immediate_byte(immediate_byte), .bank_sel(bank_sel), .peek_sel(peek_sel),
    .peek_data(peek_data), .result_data(result_data), .zero_flag(zero_flag),
    .carry_flag(carry_flag));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // valid stays high so calls run back to back; idle drops it
  task automatic op(input bala_op_t o, input logic [3:0] d, input logic im,
      input logic [3:0] s, input logic [7:0] k, input logic [7:0] er, input logic [1:0] zc);
    exec_valid = 1'h1;
    exec_op = o;
    dest_sel = d;
    use_immediate = im;
    src_sel = s;
    immediate_byte = k;
    @(negedge clk_sys);
    chk(result_data, er);
    chk({6'h00, zero_flag, carry_flag}, {6'h00, zc});
  endtask
  task automatic idle();
    exec_valid = 1'h0;
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic b, input logic [3:0] p, input logic [7:0] e);
    bank_sel = b;
    peek_sel = p;
    @(negedge clk_sys);
    chk(peek_data, e);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_or();
    op(BALA_OP_OR, 4'h1, I, 4'h0, 8'hca, 8'hca, 2'h0);
    op(BALA_OP_OR, 4'h2, I, 4'h0, 8'h14, 8'h14, 2'h0);
    op(BALA_OP_OR, 4'h1, R, 4'h2, 8'h00, 8'hde, 2'h0);
    op(BALA_OP_ADD, 4'h2, I, 4'h0, 8'hff, 8'h13, 2'h1);
    op(BALA_OP_OR, 4'h4, I, 4'h0, 8'h00, 8'h00, 2'h2);
    idle();
    rd(1'h0, 4'h1, 8'hde);
  endtask
  task automatic t_xor();
    op(BALA_OP_XOR, 4'h5, I, 4'h0, 8'hca, 8'hca, 2'h0);
    op(BALA_OP_XOR, 4'h5, I, 4'h0, 8'h53, 8'h99, 2'h0);
    op(BALA_OP_ADD, 4'h1, I, 4'h0, 8'h80, 8'h5e, 2'h1);
    op(BALA_OP_XOR, 4'h5, R, 4'h5, 8'h00, 8'h00, 2'h2);
    idle();
    rd(1'h0, 4'h5, 8'h00);
  endtask
  task automatic t_add();
    op(BALA_OP_OR, 4'h7, I, 4'h0, 8'h8e, 8'h8e, 2'h0);
    op(BALA_OP_ADD, 4'h7, I, 4'h0, 8'h43, 8'hd1, 2'h0);
    op(BALA_OP_OR, 4'h8, I, 4'h0, 8'h8e, 8'h8e, 2'h0);
    op(BALA_OP_ADD, 4'h8, R, 4'h8, 8'h00, 8'h1c, 2'h1);
    op(BALA_OP_ADD, 4'h7, I, 4'h0, 8'h2f, 8'h00, 2'h3);
    idle();
    rd(1'h0, 4'h8, 8'h1c);
  endtask
  // low byte then carry-chained high bytes; zero must track the whole value
  task automatic t_add_carry();
    op(BALA_OP_OR, 4'ha, I, 4'h0, 8'hff, 8'hff, 2'h0);
    op(BALA_OP_OR, 4'hb, I, 4'h0, 8'hff, 8'hff, 2'h0);
    op(BALA_OP_ADD, 4'ha, I, 4'h0, 8'h01, 8'h00, 2'h3);
    op(BALA_OP_ADD_CARRY, 4'hb, I, 4'h0, 8'h00, 8'h00, 2'h3);
    op(BALA_OP_ADD_CARRY, 4'hb, I, 4'h0, 8'h00, 8'h01, 2'h0);
    op(BALA_OP_ADD_CARRY, 4'hb, I, 4'h0, 8'hff, 8'h00, 2'h1);
    idle();
    rd(1'h0, 4'hb, 8'h00);
  endtask
  task automatic t_sub();
    op(BALA_OP_OR, 4'hc, I, 4'h0, 8'h8e, 8'h8e, 2'h0);
    op(BALA_OP_SUB, 4'hc, I, 4'h0, 8'h43, 8'h4b, 2'h0);
    op(BALA_OP_SUB, 4'hc, R, 4'hc, 8'h00, 8'h00, 2'h2);
    op(BALA_OP_OR, 4'hd, I, 4'h0, 8'h8e, 8'h8e, 2'h0);
    op(BALA_OP_SUB, 4'hd, I, 4'h0, 8'hb5, 8'hd9, 2'h1);
    idle();
    rd(1'h0, 4'hd, 8'hd9);
  endtask
  // runs in the second bank, so it also shows the banks are separate
  task automatic t_sub_borrow();
    bank_sel = 1'h1;
    op(BALA_OP_OR, 4'h0, I, 4'h0, 8'h7b, 8'h7b, 2'h0);
    op(BALA_OP_OR, 4'h1, I, 4'h0, 8'ha2, 8'ha2, 2'h0);
    op(BALA_OP_SUB, 4'h0, I, 4'h0, 8'hb9, 8'hc2, 2'h1);
    op(BALA_OP_SUB_BORROW, 4'h1, I, 4'h0, 8'ha1, 8'h00, 2'h0);
    op(BALA_OP_SUB, 4'h0, R, 4'h0, 8'h00, 8'h00, 2'h2);
    op(BALA_OP_SUB_BORROW, 4'h1, R, 4'h1, 8'h00, 8'h00, 2'h2);
    op(BALA_OP_SUB, 4'h2, I, 4'h0, 8'h01, 8'hff, 2'h1);
    op(BALA_OP_SUB_BORROW, 4'h3, I, 4'h0, 8'h00, 8'hff, 2'h1);
    op(BALA_OP_OR, 4'hf, I, 4'h0, 8'h3c, 8'h3c, 2'h0);
    idle();
    rd(1'h1, 4'hf, 8'h3c);
    rd(1'h0, 4'hf, 8'h00);
    rd(1'h0, 4'h1, 8'h5e);
  endtask
  // a stale add left on the bus with exec_valid low must change nothing
  task automatic t_hold();
    op(BALA_OP_OR, 4'h6, I, 4'h0, 8'h5a, 8'h5a, 2'h0);
    exec_valid = 1'h0;
    exec_op = BALA_OP_ADD;
    immediate_byte = 8'hff;
    repeat (3) @(negedge clk_sys);
    chk(result_data, 8'h5a);
    chk({6'h00, zero_flag, carry_flag}, 8'h00);
    rd(1'h0, 4'h6, 8'h5a);
  endtask
  // a second reset in mid-run clears banks, result and flags
  task automatic t_reset();
    bank_sel = 1'h1;
    op(BALA_OP_OR, 4'h9, I, 4'h0, 8'h81, 8'h81, 2'h0);
    exec_valid = 1'h0;
    nrst = 1'h0;
    repeat (2) @(negedge clk_sys);
    nrst = 1'h1;
    @(negedge clk_sys);
    chk(result_data, 8'h00);
    chk({6'h00, zero_flag, carry_flag}, 8'h00);
    rd(1'h1, 4'h9, 8'h00);
    op(BALA_OP_ADD, 4'h9, I, 4'h0, 8'h81, 8'h81, 2'h0);
  endtask
  // ==========================================================
  // run control
  task automatic print_verdict();
    $display("Errors %0d, checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    nrst = 1'h1;
    @(negedge clk_sys);
    chk(result_data, 8'h00);
    chk({6'h00, zero_flag, carry_flag}, 8'h00);
    t_or();
    t_xor();
    t_add();
    t_add_carry();
    t_sub();
    t_sub_borrow();
    t_hold();
    t_reset();
    print_verdict();
  end
  // about 60 cycles are needed; allow many times that
  initial begin
    #(40 * 2000);
    n_errors++;
    print_verdict();
  end
endmodule
